// *** adsp_cfg.svh ***
// Constants of the antenna driver serial command port: command codes,
// field positions, reset values and serial timing.
// Assumes inclusion by bare name from the package, the command port, the master model and the bench.
// Operation
// - Power-down keeps inverters off, pull-down on; enabling releases pull-down, powers inverters.
// - Qualified resonator clock switches off one of the two driver inverters.
// - Reset input is pulled to its passive level internally.
// - Chip select is pulled inactive internally, keeping port and output disabled.
// - Port works on eight-bit words with serial clock at most 1 MHz.
// - Serial output is high impedance when deselected, driven only while selected.
// - Device is slave only; master supplies chip select and clock.
// - While selected, data input is sampled on every rising serial clock edge.
// - Output shows shift register LSB; register shifts on each falling edge after a rise, except after a word's eighth rise, where it loads the response.
// - Both idle-low mode 0 and idle-high mode 3 transfers work.
// - Every first byte answers system-ready in bit 7, modulator-ready in bit 1.
// - Byte with bits 4 and 0 set clears the fault memory.
// - Bits 5,0 stop the modulator; bits 6,0 enable power-down.
// - Register 1 write stores coil code from bits 5..2, modulation type bit 0.
// - Register 1 read ignores second input, returns coil code and modulation type.
// - Register 2 write stores baud code bits 2..1, prescaler enable bit 0.
// - Register 2 read ignores second input, returns baud code and prescaler enable.
// - Every word is shifted least significant bit first, both directions.
// - Second byte of a register write returns the first command byte.
`ifndef ADSP_CFG_SVH
`define ADSP_CFG_SVH

`define ADSP_CMD_STATUS     8'h00
`define ADSP_CMD_FAULT_CLR  8'h11
`define ADSP_CMD_MOD_STOP   8'h21
`define ADSP_CMD_PWR_DOWN   8'h41
`define ADSP_CMD_WR_REG1    8'h04
`define ADSP_CMD_RD_REG1    8'h06
`define ADSP_CMD_WR_REG2    8'h08
`define ADSP_CMD_RD_REG2    8'h0A

`define ADSP_STAT_SR_BIT    7
`define ADSP_STAT_RTS_BIT   1
`define ADSP_REG1_COIL_LSB  2
`define ADSP_REG1_AP_BIT    0
`define ADSP_REG2_BAUD_LSB  1
`define ADSP_REG2_PS_BIT    0

`define ADSP_REG1_COIL_RST  4'h0
`define ADSP_REG1_AP_RST    1'h0
`define ADSP_REG2_BAUD_RST  2'h0
`define ADSP_REG2_PS_RST    1'h0

`define ADSP_WORD_BITS      8
`define ADSP_REF_CLK_HZ     40000000
`define ADSP_SCLK_MAX_HZ    1000000
`define ADSP_SCLK_HALF_CYC  (`ADSP_REF_CLK_HZ / (2 * `ADSP_SCLK_MAX_HZ))

`endif

// *** adsp_pkg.sv ***
// Types of the antenna driver serial command port.
// Assumes adsp_cfg.svh is on the include path.
`default_nettype none
package adsp_pkg;
  `include "adsp_cfg.svh"

  typedef enum logic [1:0] {
    OSC_OFF,
    OSC_START,
    OSC_RUN
  } adsp_osc_e;

  typedef logic [`ADSP_WORD_BITS-1:0] adsp_byte_t;
endpackage : adsp_pkg
`default_nettype wire

// *** adsp_cmd_port.sv ***
// Serial command port of the antenna driver with oscillator control.
// Assumes serial pins are synchronous to ref_clk, which runs at least 20x
// faster than the serial clock so every edge is seen.
`default_nettype none
`include "adsp_cfg.svh"

// Registered history of one synchronous pin, giving its edges as
// combinational strobes; the reset level should match the pin's idle
// level so that no false edge follows reset.
module adsp_edge_det
  import adsp_pkg::*;
#(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic prev_r, prev_nxt;

  always_comb begin
    prev_nxt = level;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= IDLE_LEVEL;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

endmodule : adsp_edge_det

module adsp_cmd_port
  import adsp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       chipSelect,
  input  wire logic       serialClk,
  input  wire logic       serialDataIn,
  input  wire logic       resonatorClockOk,
  input  wire logic       modulatorReady,
  output logic            serialDataOut,
  output logic            serialDataOutEn,
  output logic            resetPullupEn,
  output logic            chipSelectPulldownEn,
  output logic            resonatorPulldownEn,
  output logic            oscInverterMainEn,
  output logic            oscInverterAuxEn,
  output logic            systemReadyFlag,
  output logic [3:0]      coilCurrentCode,
  output logic            modulationTypeSel,
  output logic [1:0]      baudRateCode,
  output logic            clockOutPrescaleEn,
  output logic            faultClearPulse,
  output logic            modulatorStopPulse
);

  // Serial state
  adsp_byte_t rxShift_r,  rxShift_nxt;
  adsp_byte_t txShift_r,  txShift_nxt;
  adsp_byte_t cmd_r,      cmd_nxt;
  adsp_byte_t resp_r,     resp_nxt;
  logic [2:0] bitCnt_r,   bitCnt_nxt;
  logic       byteIdx_r,  byteIdx_nxt;
  logic       riseSeen_r, riseSeen_nxt;
  logic       loadPend_r, loadPend_nxt;
  logic       pdArm_r,    pdArm_nxt;
  logic       doEn_r,     doEn_nxt;
  logic       fltClr_r,   fltClr_nxt;
  logic       modStop_r,  modStop_nxt;
  logic [3:0] coil_r,     coil_nxt;
  logic       ap_r,       ap_nxt;
  logic [1:0] baud_r,     baud_nxt;
  logic       ps_r,       ps_nxt;

  // Oscillator state
  adsp_osc_e  oscState_r, oscState_nxt;
  logic       pullDn_r,   pullDn_nxt;
  logic       invMain_r,  invMain_nxt;
  logic       invAux_r,   invAux_nxt;
  logic       sysRdy_r,   sysRdy_nxt;

  logic       sclkUp;
  logic       sclkDown;
  logic       csUp;
  logic       csDown;
  logic       sclkRise;
  logic       sclkFall;
  logic       csStart;
  logic       pdGo;
  adsp_byte_t rxByte;
  adsp_byte_t statusByte;
  adsp_byte_t reg1Byte;
  adsp_byte_t reg2Byte;

  // Serial clock edges are gated by select below, so either idle level is safe
  adsp_edge_det #(
    .IDLE_LEVEL (1'b0)
  ) u_sclkEdge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .level   (serialClk),
    .rise    (sclkUp),
    .fall    (sclkDown)
  );

  // Select idles low through its pull-down, so reset agrees with the pin
  adsp_edge_det #(
    .IDLE_LEVEL (1'b0)
  ) u_csEdge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .level   (chipSelect),
    .rise    (csUp),
    .fall    (csDown)
  );

  // Edges only count while selected; the master owns the clock
  assign sclkRise = chipSelect & sclkUp;
  assign sclkFall = chipSelect & sclkDown;
  assign csStart  = csUp;
  assign pdGo     = csDown & pdArm_r;
  // New bit enters at the top so the first bit lands in bit 0
  assign rxByte   = {serialDataIn, rxShift_r[7:1]};

  always_comb begin
    statusByte = 8'h00;
    statusByte[`ADSP_STAT_SR_BIT]  = sysRdy_r;
    statusByte[`ADSP_STAT_RTS_BIT] = modulatorReady;
    reg1Byte = 8'h00;
    reg1Byte[`ADSP_REG1_COIL_LSB +: 4] = coil_r;
    reg1Byte[`ADSP_REG1_AP_BIT]        = ap_r;
    reg2Byte = 8'h00;
    reg2Byte[`ADSP_REG2_BAUD_LSB +: 2] = baud_r;
    reg2Byte[`ADSP_REG2_PS_BIT]        = ps_r;
  end

  // Serial engine and configuration registers
  always_comb begin
    rxShift_nxt  = rxShift_r;
    txShift_nxt  = txShift_r;
    cmd_nxt      = cmd_r;
    resp_nxt     = resp_r;
    bitCnt_nxt   = bitCnt_r;
    byteIdx_nxt  = byteIdx_r;
    riseSeen_nxt = riseSeen_r;
    loadPend_nxt = loadPend_r;
    pdArm_nxt    = pdArm_r;
    doEn_nxt     = chipSelect;
    fltClr_nxt   = 1'b0;
    modStop_nxt  = 1'b0;
    coil_nxt     = coil_r;
    ap_nxt       = ap_r;
    baud_nxt     = baud_r;
    ps_nxt       = ps_r;
    if (!chipSelect) begin
      bitCnt_nxt   = 3'h0;
      byteIdx_nxt  = 1'b0;
      riseSeen_nxt = 1'b0;
      loadPend_nxt = 1'b0;
      if (csDown) begin
        pdArm_nxt = 1'b0;
      end
    end else if (csStart) begin
      txShift_nxt  = statusByte;
      bitCnt_nxt   = 3'h0;
      byteIdx_nxt  = 1'b0;
      riseSeen_nxt = 1'b0;
      loadPend_nxt = 1'b0;
    end else if (sclkRise) begin
      rxShift_nxt  = rxByte;
      bitCnt_nxt   = bitCnt_r + 3'h1;
      riseSeen_nxt = 1'b1;
      if (bitCnt_r == 3'h7) begin
        loadPend_nxt = 1'b1;
        resp_nxt     = statusByte;
        if (!byteIdx_r) begin
          cmd_nxt   = rxByte;
          pdArm_nxt = 1'b0;
          case (rxByte)
            `ADSP_CMD_STATUS: begin
              resp_nxt = statusByte;
            end
            `ADSP_CMD_FAULT_CLR: begin
              fltClr_nxt = 1'b1;
            end
            `ADSP_CMD_MOD_STOP: begin
              modStop_nxt = 1'b1;
            end
            `ADSP_CMD_PWR_DOWN: begin
              pdArm_nxt = 1'b1;
            end
            `ADSP_CMD_WR_REG1, `ADSP_CMD_WR_REG2: begin
              resp_nxt    = rxByte;
              byteIdx_nxt = 1'b1;
            end
            `ADSP_CMD_RD_REG1: begin
              resp_nxt    = reg1Byte;
              byteIdx_nxt = 1'b1;
            end
            `ADSP_CMD_RD_REG2: begin
              resp_nxt    = reg2Byte;
              byteIdx_nxt = 1'b1;
            end
            default: begin
              resp_nxt = statusByte;
            end
          endcase
        end else begin
          byteIdx_nxt = 1'b0;
          if (cmd_r == `ADSP_CMD_WR_REG1) begin
            coil_nxt = rxByte[`ADSP_REG1_COIL_LSB +: 4];
            ap_nxt   = rxByte[`ADSP_REG1_AP_BIT];
          end else if (cmd_r == `ADSP_CMD_WR_REG2) begin
            baud_nxt = rxByte[`ADSP_REG2_BAUD_LSB +: 2];
            ps_nxt   = rxByte[`ADSP_REG2_PS_BIT];
          end
        end
      end
    end else if (sclkFall) begin
      // A fall before any rise (mode 3 lead-in) leaves bit 0 in place
      if (loadPend_r) begin
        txShift_nxt  = resp_r;
        loadPend_nxt = 1'b0;
        riseSeen_nxt = 1'b0;
      end else if (riseSeen_r) begin
        txShift_nxt = {1'b0, txShift_r[7:1]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift_r  <= 8'h00;
      txShift_r  <= 8'h00;
      cmd_r      <= 8'h00;
      resp_r     <= 8'h00;
      bitCnt_r   <= 3'h0;
      byteIdx_r  <= 1'b0;
      riseSeen_r <= 1'b0;
      loadPend_r <= 1'b0;
      pdArm_r    <= 1'b0;
      doEn_r     <= 1'b0;
      fltClr_r   <= 1'b0;
      modStop_r  <= 1'b0;
      coil_r     <= `ADSP_REG1_COIL_RST;
      ap_r       <= `ADSP_REG1_AP_RST;
      baud_r     <= `ADSP_REG2_BAUD_RST;
      ps_r       <= `ADSP_REG2_PS_RST;
    end else begin
      rxShift_r  <= rxShift_nxt;
      txShift_r  <= txShift_nxt;
      cmd_r      <= cmd_nxt;
      resp_r     <= resp_nxt;
      bitCnt_r   <= bitCnt_nxt;
      byteIdx_r  <= byteIdx_nxt;
      riseSeen_r <= riseSeen_nxt;
      loadPend_r <= loadPend_nxt;
      pdArm_r    <= pdArm_nxt;
      doEn_r     <= doEn_nxt;
      fltClr_r   <= fltClr_nxt;
      modStop_r  <= modStop_nxt;
      coil_r     <= coil_nxt;
      ap_r       <= ap_nxt;
      baud_r     <= baud_nxt;
      ps_r       <= ps_nxt;
    end
  end

  // Oscillator enable and qualification
  always_comb begin
    oscState_nxt = oscState_r;
    case (oscState_r)
      OSC_OFF: begin
        if (chipSelect) begin
          oscState_nxt = OSC_START;
        end
      end
      OSC_START: begin
        if (resonatorClockOk) begin
          oscState_nxt = OSC_RUN;
        end
      end
      OSC_RUN: begin
        oscState_nxt = OSC_RUN;
      end
      default: begin
        oscState_nxt = OSC_OFF;
      end
    endcase
    if (pdGo) begin
      oscState_nxt = OSC_OFF;
    end
    pullDn_nxt  = (oscState_nxt == OSC_OFF);
    invMain_nxt = (oscState_nxt != OSC_OFF);
    invAux_nxt  = (oscState_nxt == OSC_START);
    sysRdy_nxt  = (oscState_nxt == OSC_RUN);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscState_r <= OSC_OFF;
      pullDn_r   <= 1'b1;
      invMain_r  <= 1'b0;
      invAux_r   <= 1'b0;
      sysRdy_r   <= 1'b0;
    end else begin
      oscState_r <= oscState_nxt;
      pullDn_r   <= pullDn_nxt;
      invMain_r  <= invMain_nxt;
      invAux_r   <= invAux_nxt;
      sysRdy_r   <= sysRdy_nxt;
    end
  end

  // Pin keepers are constant once out of reset
  logic keep_r, keep_nxt;

  always_comb begin
    keep_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keep_r <= 1'b1;
    end else begin
      keep_r <= keep_nxt;
    end
  end

  assign resetPullupEn        = keep_r;
  assign chipSelectPulldownEn = keep_r;
  assign serialDataOut        = txShift_r[0];
  assign serialDataOutEn      = doEn_r;
  assign resonatorPulldownEn  = pullDn_r;
  assign oscInverterMainEn    = invMain_r;
  assign oscInverterAuxEn     = invAux_r;
  assign systemReadyFlag      = sysRdy_r;
  assign coilCurrentCode      = coil_r;
  assign modulationTypeSel    = ap_r;
  assign baudRateCode         = baud_r;
  assign clockOutPrescaleEn   = ps_r;
  assign faultClearPulse      = fltClr_r;
  assign modulatorStopPulse   = modStop_r;

endmodule : adsp_cmd_port
`default_nettype wire

// *** adsp_cmd_port_props.sv ***
// Concurrent checks on the serial command port pins.
// Assumes one ref_clk domain with rst_n as asynchronous active-low reset.
`default_nettype none
module adsp_cmd_port_props (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       chipSelect,
  input wire logic       serialClk,
  input wire logic       resonatorClockOk,
  input wire logic       serialDataOut,
  input wire logic       serialDataOutEn,
  input wire logic       resetPullupEn,
  input wire logic       chipSelectPulldownEn,
  input wire logic       resonatorPulldownEn,
  input wire logic       oscInverterMainEn,
  input wire logic       oscInverterAuxEn,
  input wire logic       systemReadyFlag,
  input wire logic [3:0] coilCurrentCode,
  input wire logic [1:0] baudRateCode,
  input wire logic       faultClearPulse,
  input wire logic       modulatorStopPulse
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  oe_tracks_cs_a: assert property (serialDataOutEn == $past(chipSelect))
    else $error("output enable does not follow select");
  pulls_kept_a: assert property (resetPullupEn && chipSelectPulldownEn)
    else $error("pin pull structure released");
  pd_inv_off_a: assert property (resonatorPulldownEn |-> !oscInverterMainEn && !oscInverterAuxEn)
    else $error("inverter powered in power-down");
  osc_start_a: assert property (chipSelect && resonatorPulldownEn
    |=> !resonatorPulldownEn && oscInverterMainEn && oscInverterAuxEn)
    else $error("select did not start oscillator");
  aux_drop_a: assert property (oscInverterAuxEn && resonatorClockOk
    |=> !oscInverterAuxEn && systemReadyFlag)
    else $error("aux inverter kept after clock qualified");
  pulse_single_a: assert property (faultClearPulse || modulatorStopPulse
    |=> !faultClearPulse && !modulatorStopPulse)
    else $error("command pulse longer than one cycle");
  pulse_cause_a: assert property (faultClearPulse || modulatorStopPulse
    |-> $past(chipSelect) && $past(serialClk) && !$past(serialClk, 2))
    else $error("command pulse without a selected rising edge");
  cfg_hold_a: assert property (!chipSelect
    |=> $stable(coilCurrentCode) && $stable(baudRateCode))
    else $error("configuration changed while deselected");
  dout_hold_a: assert property ($past(chipSelect) && $past(chipSelect, 2)
    && !($past(serialClk, 2) && !$past(serialClk)) |-> $stable(serialDataOut))
    else $error("serial output moved without a falling edge");
endmodule : adsp_cmd_port_props

bind adsp_cmd_port adsp_cmd_port_props u_props (
  .ref_clk, .rst_n, .chipSelect, .serialClk, .resonatorClockOk, .serialDataOut,
  .serialDataOutEn, .resetPullupEn, .chipSelectPulldownEn, .resonatorPulldownEn,
  .oscInverterMainEn, .oscInverterAuxEn, .systemReadyFlag, .coilCurrentCode,
  .baudRateCode, .faultClearPulse, .modulatorStopPulse
);
`default_nettype wire

// *** adsp_spi_master.sv ***
// Serial bus master model: select, clock and data, words LSB first.
// Assumes frame() is called from a process timed by ref_clk.
`default_nettype none
`include "adsp_cfg.svh"
module adsp_spi_master
  import adsp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic serialDataOut,
  output var logic  chipSelect,
  output var logic  serialClk,
  output var logic  serialDataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = `ADSP_SCLK_HALF_CYC; // Half period at 1 MHz

  initial begin
    chipSelect = 1'b0;
    serialClk = 1'b0;
    serialDataIn = 1'b0;
  end

  task automatic frame(input int nb, input logic m3, input logic [15:0] tx,
                       output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge ref_clk);
    serialClk <= m3; // Idle level of the chosen mode
    @(posedge ref_clk);
    chipSelect <= 1'b1; // Only the master opens an exchange
    repeat (HALF) @(posedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      if (m3) serialClk <= 1'b0;
      serialDataIn <= tx[i]; // LSB first
      repeat (HALF) @(posedge ref_clk);
      rx[i] = serialDataOut;
      serialClk <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
      if (!m3) serialClk <= 1'b0;
    end
    repeat (HALF) @(posedge ref_clk);
    chipSelect <= 1'b0;
    serialDataIn <= ~serialDataIn; // Released line shows no stale bit
    repeat (HALF) @(posedge ref_clk);
  endtask : frame
endmodule : adsp_spi_master
`default_nettype wire

// *** antenna_driver_spi_cmd_port_test.sv ***
// Self-checking bench of the serial command port with a master model.
// Assumes adsp_pkg, the checker and the master model are compiled first.
`default_nettype none
`include "adsp_cfg.svh"
module antenna_driver_spi_cmd_port_test
  import adsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic resonatorClockOk = 1'b0;
  logic modulatorReady = 1'b0;
  wire logic chipSelect, serialClk, serialDataIn, sdoLine;
  logic serialDataOut, serialDataOutEn, resetPullupEn, chipSelectPulldownEn;
  logic resonatorPulldownEn, oscInverterMainEn, oscInverterAuxEn, systemReadyFlag;
  logic modulationTypeSel, clockOutPrescaleEn, faultClearPulse, modulatorStopPulse;
  logic [3:0] coilCurrentCode;
  logic [1:0] baudRateCode;
  logic [15:0] rx;
  logic [7:0] r1 = 8'h00, r2 = 8'h00;
  logic run = 1'b0;
  int err_total = 0, cmp_count = 0, cycles = 0;
  int fltCnt = 0, stopCnt = 0, fe = 0, se = 0;
  logic [7:0] tbl [8] = '{`ADSP_CMD_STATUS, `ADSP_CMD_FAULT_CLR, `ADSP_CMD_MOD_STOP,
    `ADSP_CMD_WR_REG1, `ADSP_CMD_RD_REG1, `ADSP_CMD_WR_REG2, `ADSP_CMD_RD_REG2, 8'hFF};
  int nbt [8] = '{8, 8, 8, 16, 16, 16, 16, 8};

  always #12.5 ref_clk = ~ref_clk;

  // A deselected output floats; the model then sees the opposite of the last bit
  assign sdoLine = serialDataOutEn ? serialDataOut : ~serialDataOut;
  adsp_spi_master m (.ref_clk, .serialDataOut(sdoLine), .chipSelect, .serialClk,
    .serialDataIn);
  adsp_cmd_port DUT (.ref_clk, .rst_n, .chipSelect, .serialClk, .serialDataIn,
    .resonatorClockOk, .modulatorReady, .serialDataOut, .serialDataOutEn,
    .resetPullupEn, .chipSelectPulldownEn, .resonatorPulldownEn, .oscInverterMainEn,
    .oscInverterAuxEn, .systemReadyFlag, .coilCurrentCode, .modulationTypeSel,
    .baudRateCode, .clockOutPrescaleEn, .faultClearPulse, .modulatorStopPulse);

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [7:0] stat_exp(input logic s, input logic r);
    return {s, 5'h00, r, 1'b0};
  endfunction : stat_exp

  function automatic logic [7:0] exp2(input logic [7:0] c);
    if (c == `ADSP_CMD_RD_REG1) return {2'h0, r1[5:2], 1'b0, r1[0]};
    if (c == `ADSP_CMD_RD_REG2) return {5'h00, r2[2:0]};
    return c;
  endfunction : exp2

  task automatic cmd(input logic [7:0] c, input logic [7:0] d, input int nb);
    m.frame(nb, 1'($urandom), {d, c}, rx);
    if (nb >= 8) chk(rx[7:0], stat_exp(run, modulatorReady));
    if (nb == 16) chk(rx[15:8], exp2(c));
    if (nb == 16 && c == `ADSP_CMD_WR_REG1) r1 = d;
    if (nb == 16 && c == `ADSP_CMD_WR_REG2) r2 = d;
    if (nb >= 8 && c == `ADSP_CMD_FAULT_CLR) fe++;
    if (nb >= 8 && c == `ADSP_CMD_MOD_STOP) se++;
    run = (c != `ADSP_CMD_PWR_DOWN) && resonatorClockOk;
    modulatorReady <= 1'($urandom);
    chk(8'({coilCurrentCode, modulationTypeSel}), {3'h0, r1[5:2], r1[0]});
    chk(8'({baudRateCode, clockOutPrescaleEn}), {5'h00, r2[2:0]});
    chk(8'(fltCnt), 8'(fe));
    chk(8'(stopCnt), 8'(se));
  endtask : cmd

  // Pulse counters and the hang limit
  always @(posedge ref_clk) begin
    cycles++;
    if (faultClearPulse === 1'b1) fltCnt++;
    if (modulatorStopPulse === 1'b1) stopCnt++;
    if (cycles == 60000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'hADFC));
    repeat (20) @(posedge ref_clk);
    chk(8'({resetPullupEn, chipSelectPulldownEn, resonatorPulldownEn, oscInverterMainEn,
      oscInverterAuxEn}), 8'h1C);
    rst_n <= 1'b1;
    cmd(`ADSP_CMD_STATUS, 8'h00, 8);
    chk(8'({resonatorPulldownEn, oscInverterAuxEn}), 8'h01);
    resonatorClockOk <= 1'b1;
    repeat (3) @(posedge ref_clk);
    run = 1'b1;
    chk(8'({oscInverterMainEn, oscInverterAuxEn, systemReadyFlag}), 8'h05);
    for (int i = 0; i < 24; i++) begin
      cmd(tbl[i % 8], 8'($urandom), nbt[i % 8]);
    end
    cmd(`ADSP_CMD_WR_REG1, ~r1, 13);
    cmd(`ADSP_CMD_PWR_DOWN, 8'h00, 8);
    chk(8'({resonatorPulldownEn, oscInverterMainEn, systemReadyFlag}), 8'h04);
    cmd(`ADSP_CMD_STATUS, 8'h00, 8);
    cmd(`ADSP_CMD_STATUS, 8'h00, 8);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    r1 = 8'h00;
    r2 = 8'h00;
    run = 1'b0;
    cmd(`ADSP_CMD_RD_REG1, 8'hFF, 16);
    cmd(`ADSP_CMD_RD_REG2, 8'hFF, 16);
    close_out();
  end
endmodule : antenna_driver_spi_cmd_port_test
`default_nettype wire
